// file: logic/fan_pwm_pkg.sv
package fan_pwm_pkg;

   localparam int unsigned CLK_HZ            = 125_000_000;
   localparam int unsigned CLK_PERIOD_NS     = 8;
   localparam int unsigned PWM_FREQ_HZ       = 30;
   localparam int unsigned PWM_PERIOD_CYCLES = CLK_HZ / PWM_FREQ_HZ;
   localparam int unsigned DUTY_W            = 8;
   localparam int unsigned DUTY_STEPS        = 256;
   localparam int unsigned PRESC_W           = 24;
   localparam int unsigned PCNT_W            = 6;
   localparam int unsigned BLANK_W           = 8;

   // interval lengths, stored as last period index
   localparam logic [PCNT_W-1:0] START_LAST = 6'h1f;
   localparam logic [PCNT_W-1:0] MISS_LAST  = 6'h1f;
   localparam logic [PCNT_W-1:0] DIAG_LAST  = 6'h02;

   localparam int unsigned BLANK_TIME_NS = 2000;
   localparam int unsigned BLANK_CYCLES  =
      (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam logic               DRIVE_RST   = 1'b0;
   localparam logic               FAULT_N_RST = 1'b1;
   localparam logic [DUTY_W-1:0]  DUTY_RST    = 8'h00;
   localparam logic [PRESC_W-1:0] PRESC_RST   = 24'h000000;
   localparam logic [PCNT_W-1:0]  PCNT_RST    = 6'h00;
   localparam logic [BLANK_W-1:0] BLANK_RST   = 8'h00;

   typedef enum logic [2:0] {
      ST_OFF     = 3'b000,
      ST_START1  = 3'b001,
      ST_START2  = 3'b011,
      ST_RUN     = 3'b010,
      ST_DIAG    = 3'b110,
      ST_RESTART = 3'b111,
      ST_FAULT   = 3'b101
   } fan_state_t;

   typedef struct packed {
      logic shutdown;
      logic release_ok;
      logic sense;
   } pin_sample_t;

   typedef struct packed {
      logic [DUTY_W-1:0] temp;
      logic [DUTY_W-1:0] min_speed;
   } level_pair_t;

endpackage

// file: logic/fan_pwm_supervisor.sv
// Summary of operation
// RL1: run loop exits only by shutdown or missing-pulse timeout
// RL2: per-period loop, period counter cleared by a valid pulse or a state change
// RL3: shutdown zeroes drive, fault inactive, leaves loop
// RL4: after shutdown wait release, then power-up restart
// RL5: run duty follows larger of two levels
// RL6: valid pulse restarts missing-pulse counting
// RL7: missing-pulse timeout after thirty-two periods
// RL8: timeout starts three-period diagnostic interval
// RL9: drive held on through diagnostic interval
// RL10: no pulse: thirty-two-period start-up; pulse returns
// RL11: start-up without pulse enters fan fault
// RL12: fault holds fault low, drive off
// RL13: fault persists until shutdown-release or power cycle
// RL14: shutdown then release leaves fault to power-up
// RL15: power-up drives fan on thirty-two periods
// RL16: repeat start interval once, then fault
// RL17: blank sense pulses caused by drive turn-on
// RL18: fault output inactive whenever shutdown requested
// RL19: level and control inputs synchronised before use
// RL20: shutdown overrides all states, clears timers
`timescale 1ns/1ps
module fan_pwm_supervisor
   import fan_pwm_pkg::*;
#(
   parameter int unsigned PWM_PERIOD = PWM_PERIOD_CYCLES
)(
   input  wire logic              ref_clk,
   input  wire logic              nrst,
   input  wire logic              shutdown_req,
   input  wire logic              release_ok,
   input  wire logic              sense_pulse,
   input  wire logic [DUTY_W-1:0] temp_level,
   input  wire logic [DUTY_W-1:0] min_speed_level,
   output logic                   fan_drive_out,
   output logic                   fault_n
);

   // period must be at least DUTY_STEPS cycles
   localparam logic [PRESC_W-1:0] STEP_LAST =
      PRESC_W'(PWM_PERIOD / DUTY_STEPS - 1);
   localparam logic [BLANK_W-1:0] BLANK_LOAD = BLANK_W'(BLANK_CYCLES);
   localparam logic [DUTY_W-1:0]  PHASE_LAST = 8'hff;

   pin_sample_t       sync1_q, sync2_q;
   level_pair_t       lvl1_q, lvl2_q;
   logic              sense_dly_q;
   fan_state_t        state_q, state_d;
   logic [PRESC_W-1:0] presc_q, presc_d;
   logic [DUTY_W-1:0] phase_q, phase_d;
   logic [DUTY_W-1:0] duty_q, duty_d;
   logic [PCNT_W-1:0] pcnt_q, pcnt_d;
   logic [BLANK_W-1:0] blank_q, blank_d;
   logic              drive_q, drive_d;
   logic              fault_n_q, fault_n_d;
   logic              sd;
   logic              step_en;
   logic              period_end;
   logic              pulse_seen;

   // levels are multi-bit; a torn sample lasts one cycle and only
   // matters when latched at a period end or on leaving shutdown, accepted as harmless
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         sync1_q     <= '0;
         sync2_q     <= '0;
         lvl1_q      <= '0;
         lvl2_q      <= '0;
         sense_dly_q <= 1'b0;
      end else begin
         sync1_q     <= {shutdown_req, release_ok, sense_pulse}; // [RL19]
         sync2_q     <= sync1_q;
         lvl1_q      <= {temp_level, min_speed_level}; // [RL19]
         lvl2_q      <= lvl1_q;
         sense_dly_q <= sync2_q.sense;
      end
   end

   always_comb begin
      sd         = sync2_q.shutdown;
      step_en    = (presc_q == STEP_LAST);
      period_end = step_en && (phase_q == PHASE_LAST);
      // only edges outside the turn-on blanking window count
      pulse_seen = sync2_q.sense && !sense_dly_q
                   && (blank_q == BLANK_RST); // [RL17]

      state_d = state_q;
      unique case (state_q)
         ST_OFF: begin
            if (sync2_q.release_ok) begin
               state_d = ST_START1; // [RL4] [RL14]
            end
         end
         ST_START1: begin
            if (pulse_seen) begin
               state_d = ST_RUN;
            end else if (period_end && pcnt_q == START_LAST) begin
               state_d = ST_START2; // [RL16]
            end
         end
         ST_START2: begin
            if (pulse_seen) begin
               state_d = ST_RUN;
            end else if (period_end && pcnt_q == START_LAST) begin
               state_d = ST_FAULT; // [RL16]
            end
         end
         ST_RUN: begin
            // besides the shutdown override below, only the missing-pulse path leaves the loop
            if (!pulse_seen && period_end && pcnt_q == MISS_LAST) begin
               state_d = ST_DIAG; // [RL1] [RL7] [RL8]
            end
         end
         ST_DIAG: begin
            if (pulse_seen) begin
               state_d = ST_RUN; // [RL10]
            end else if (period_end && pcnt_q == DIAG_LAST) begin
               state_d = ST_RESTART; // [RL10]
            end
         end
         ST_RESTART: begin
            if (pulse_seen) begin
               state_d = ST_RUN; // [RL10]
            end else if (period_end && pcnt_q == START_LAST) begin
               state_d = ST_FAULT; // [RL11]
            end
         end
         ST_FAULT: begin
            state_d = ST_FAULT; // [RL13]
         end
         default: begin
            state_d = ST_OFF;
         end
      endcase
      if (sd) begin
         state_d = ST_OFF; // [RL3] [RL20]
      end

      // time base, frozen and cleared in shutdown
      if (state_d == ST_OFF) begin
         presc_d = PRESC_RST; // [RL20]
         phase_d = DUTY_RST;
      end else if (step_en) begin
         presc_d = PRESC_RST;
         phase_d = phase_q + 8'h01;
      end else begin
         presc_d = presc_q + 24'h000001;
         phase_d = phase_q;
      end

      if (state_d == ST_OFF) begin
         duty_d = DUTY_RST;
      end else if (period_end || state_q == ST_OFF) begin
         duty_d = (lvl2_q.temp > lvl2_q.min_speed) ? lvl2_q.temp
                                                   : lvl2_q.min_speed; // [RL5]
      end else begin
         duty_d = duty_q;
      end

      if (state_d != state_q || (state_q == ST_RUN && pulse_seen)) begin
         pcnt_d = PCNT_RST; // [RL2] [RL6]
      end else if (period_end) begin
         pcnt_d = pcnt_q + 6'h01;
      end else begin
         pcnt_d = pcnt_q;
      end

      unique case (state_d)
         ST_OFF:     drive_d = 1'b0; // [RL3]
         ST_FAULT:   drive_d = 1'b0; // [RL12]
         ST_RUN:     drive_d = (phase_d < duty_d); // [RL5]
         ST_DIAG:    drive_d = 1'b1; // [RL9]
         ST_START1,
         ST_START2,
         ST_RESTART: drive_d = 1'b1; // [RL15]
         default:    drive_d = 1'b0;
      endcase

      if (drive_d && !drive_q) begin
         blank_d = BLANK_LOAD; // [RL17]
      end else if (blank_q != BLANK_RST) begin
         blank_d = blank_q - 8'h01;
      end else begin
         blank_d = blank_q;
      end

      fault_n_d = sd || (state_d != ST_FAULT); // [RL12] [RL18]
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         state_q   <= ST_OFF;
         presc_q   <= PRESC_RST;
         phase_q   <= DUTY_RST;
         duty_q    <= DUTY_RST;
         pcnt_q    <= PCNT_RST;
         blank_q   <= BLANK_RST;
         drive_q   <= DRIVE_RST;
         fault_n_q <= FAULT_N_RST;
      end else begin
         state_q   <= state_d;
         presc_q   <= presc_d;
         phase_q   <= phase_d;
         duty_q    <= duty_d;
         pcnt_q    <= pcnt_d;
         blank_q   <= blank_d;
         drive_q   <= drive_d;
         fault_n_q <= fault_n_d;
      end
   end

   assign fan_drive_out = drive_q;
   assign fault_n       = fault_n_q;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   shutdown_off_a: assert property ( // [RL3]
      sd |=> state_q == ST_OFF && !fan_drive_out && fault_n)
      else $error("shutdown did not force off");
   fault_inactive_a: assert property ( // [RL18]
      state_q == ST_FAULT && sd |=> fault_n)
      else $error("fault low while shutdown requested");
   fault_hold_a: assert property ( // [RL12]
      state_q == ST_FAULT |-> !fan_drive_out && !fault_n)
      else $error("fault state outputs wrong");
   fault_latch_a: assert property ( // [RL13]
      state_q == ST_FAULT && !sd |=> state_q == ST_FAULT)
      else $error("fault left without shutdown");
   release_start_a: assert property ( // [RL4]
      state_q == ST_OFF && !sd && sync2_q.release_ok
      |=> state_q == ST_START1 && fan_drive_out)
      else $error("release did not start fan");
   diag_drive_a: assert property ( // [RL9]
      state_q == ST_DIAG |-> fan_drive_out)
      else $error("drive low during diagnostic");
   start_drive_a: assert property ( // [RL15]
      state_q inside {ST_START1, ST_START2, ST_RESTART} |-> fan_drive_out)
      else $error("drive low during start-up");
   miss_timeout_a: assert property ( // [RL7]
      state_q == ST_RUN && period_end && pcnt_q == MISS_LAST
      && !pulse_seen && !sd |=> state_q == ST_DIAG && pcnt_q == PCNT_RST)
      else $error("missing-pulse timeout not taken");
   diag_end_a: assert property ( // [RL8]
      state_q == ST_DIAG && period_end && pcnt_q == DIAG_LAST
      && !pulse_seen && !sd |=> state_q == ST_RESTART)
      else $error("diagnostic interval length wrong");
   restart_fault_a: assert property ( // [RL11]
      state_q == ST_RESTART && period_end && pcnt_q == START_LAST
      && !pulse_seen && !sd |=> state_q == ST_FAULT && !fault_n)
      else $error("failed restart did not fault");
   pulse_loop_a: assert property ( // [RL6]
      !(state_q inside {ST_OFF, ST_FAULT}) && pulse_seen && !sd
      |=> state_q == ST_RUN && pcnt_q == PCNT_RST)
      else $error("pulse did not restart loop");
   run_duty_a: assert property ( // [RL5]
      state_q == ST_RUN |-> fan_drive_out == (phase_q < duty_q))
      else $error("run drive not following duty");
   blank_load_a: assert property ( // [RL17]
      $rose(fan_drive_out) |-> blank_q == BLANK_LOAD)
      else $error("blanking not armed on turn-on");

   // sequencing checks beyond the outputs
   start_repeat_a: assert property ( // [RL16]
      state_q == ST_START1 && period_end && pcnt_q == START_LAST
      && !pulse_seen && !sd |=> state_q == ST_START2 && fan_drive_out)
      else $error("start interval not repeated");
   start_fault_a: assert property ( // [RL16]
      state_q == ST_START2 && period_end && pcnt_q == START_LAST
      && !pulse_seen && !sd |=> state_q == ST_FAULT && !fault_n)
      else $error("second start interval did not fault");
   run_stay_a: assert property ( // [RL1]
      state_q == ST_RUN && !sd && !(period_end && pcnt_q == MISS_LAST)
      |=> state_q == ST_RUN)
      else $error("run loop left without cause");
   period_count_a: assert property ( // [RL2]
      state_q == ST_RUN && !sd && !pulse_seen && period_end
      && pcnt_q != MISS_LAST |=> pcnt_q == $past(pcnt_q) + 6'h01)
      else $error("period count not advanced");
   duty_latch_a: assert property ( // [RL5]
      state_q == ST_RUN && period_end && !sd
      |=> duty_q >= $past(lvl2_q.temp) && duty_q >= $past(lvl2_q.min_speed)
      && (duty_q == $past(lvl2_q.temp) || duty_q == $past(lvl2_q.min_speed)))
      else $error("duty not the larger level");
   duty_hold_a: assert property ( // [RL5]
      state_q == ST_RUN && !period_end && !sd |=> $stable(duty_q))
      else $error("duty changed inside a period");
   shutdown_clear_a: assert property ( // [RL20]
      sd |=> presc_q == PRESC_RST && phase_q == DUTY_RST
      && duty_q == DUTY_RST && pcnt_q == PCNT_RST)
      else $error("shutdown left timers running");
   off_wait_a: assert property ( // [RL4]
      state_q == ST_OFF && !sync2_q.release_ok |=> state_q == ST_OFF
      && !fan_drive_out)
      else $error("left shutdown without release");
   fault_exit_a: assert property ( // [RL14]
      state_q == ST_FAULT && sd ##1 !sd && sync2_q.release_ok
      |=> state_q == ST_START1 && fault_n)
      else $error("release did not leave fault");

endmodule

// file: bench/fan_model.sv
`timescale 1ns/1ps
module fan_model (
   input  wire logic ref_clk,
   input  wire logic spin,
   input  wire logic fan_drive_out,
   output logic      sense_pulse
);
   logic [6:0] ph_q = 7'h00;

   always_ff @(posedge ref_clk) begin
      ph_q <= ph_q + 7'h01;
   end

   // commutation only while the coil is energised, so low duty hides pulses
   // 4-clock pulse every 128 clocks, wider than the 2-clock minimum
   assign sense_pulse = spin && (fan_drive_out === 1'b1) && (ph_q < 7'h04);
endmodule

// file: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import fan_pwm_pkg::*;
   localparam int unsigned PER = 512;
   logic              ref_clk;
   logic              nrst;
   logic              shutdown_req;
   logic              release_ok;
   logic              sense_pulse;
   logic              spin;
   logic [DUTY_W-1:0] temp_level;
   logic [DUTY_W-1:0] min_speed_level;
   logic              fan_drive_out;
   logic              fault_n;
   int                n_errors;
   int                n_compared;
   int                on;
   int                fl;

   fan_pwm_supervisor #(.PWM_PERIOD(PER)) fan_pwm_supervisor_inst (
      .ref_clk         (ref_clk),
      .nrst            (nrst),
      .shutdown_req    (shutdown_req),
      .release_ok      (release_ok),
      .sense_pulse     (sense_pulse),
      .temp_level      (temp_level),
      .min_speed_level (min_speed_level),
      .fan_drive_out   (fan_drive_out),
      .fault_n         (fault_n)
   );

   fan_model fan_model_inst (
      .ref_clk       (ref_clk),
      .spin          (spin),
      .fan_drive_out (fan_drive_out),
      .sense_pulse   (sense_pulse)
   );

   task automatic complete_run();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   // drive-high clocks and fault-low clocks over a window
   task automatic count_out(input int n);
      on = 0;
      fl = 0;
      repeat (n) begin
         @(negedge ref_clk);
         if (fan_drive_out === 1'b1) on++;
         if (fault_n === 1'b0) fl++;
      end
   endtask

   task automatic power_up_fault();
      int i;
      wait_clk(8);
      count_out(62 * PER);
      check(on, 62 * PER);
      check(fl, 0);
      for (i = 0; i < 3 * PER && fault_n !== 1'b0; i++) wait_clk(1);
      check(fault_n, 1'b0);
      count_out(PER);
      check(on, 0);
      check(fl, PER);
   endtask

   task automatic shutdown_clears_fault();
      shutdown_req = 1'b1;
      release_ok   = 1'b0;
      wait_clk(4);
      count_out(20);
      check(on, 0);
      check(fl, 0);
      spin         = 1'b1;
      shutdown_req = 1'b0;
      release_ok   = 1'b1;
      wait_clk(6);
      check(fan_drive_out, 1'b1);
   endtask

   task automatic run_duty();
      wait_clk(3 * PER);
      count_out(PER);
      check(on, 384);
      temp_level = 8'he0;
      wait_clk(2 * PER);
      count_out(PER);
      check(on, 448);
   endtask

   task automatic missing_pulse_recovery();
      spin = 1'b0;
      count_out(29 * PER);
      check(fl, 0);
      count_out(PER);
      check(on, 448);
      // past the timeout, before the restart interval can run out
      wait_clk(2 * PER + PER / 2);
      count_out(2 * PER);
      check(on, 2 * PER);
      check(fl, 0);
      spin = 1'b1;
      wait_clk(3 * PER);
      count_out(PER);
      check(on, 448);
   endtask

   task automatic shutdown_in_run();
      shutdown_req = 1'b1;
      release_ok   = 1'b0;
      wait_clk(4);
      count_out(PER);
      check(on, 0);
      check(fl, 0);
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   initial begin
      n_errors        = 0;
      n_compared      = 0;
      nrst            = 1'b0;
      shutdown_req    = 1'b0;
      release_ok      = 1'b1;
      spin            = 1'b0;
      temp_level      = 8'h40;
      min_speed_level = 8'hc0;
      wait_clk(12);
      nrst = 1'b1;
      power_up_fault();
      shutdown_clears_fault();
      run_duty();
      missing_pulse_recovery();
      shutdown_in_run();
      complete_run();
   end

   // about 57k clocks expected; generous margin before giving up
   initial begin
      #(80_000 * 8);
      n_errors++;
      complete_run();
   end
endmodule
